// [scc_consts.svh]
`ifndef SCC_CONSTS_SVH
`define SCC_CONSTS_SVH

// timing
`define SCC_CLK_NS          25
`define SCC_POR_NS          75
`define SCC_POR_CYC         ((`SCC_POR_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
`define SCC_PIN_HIZ_NS      45
`define SCC_PIN_HIZ_CYC     (`SCC_PIN_HIZ_NS / `SCC_CLK_NS)

// register offsets
`define SCC_ADR_IO_UPDATE   16'h0005
`define SCC_ADR_SYSCLK_PER  16'h0100
`define SCC_ADR_MFP_OE      16'h0200
`define SCC_ADR_MFP_OUT     16'h0201
`define SCC_ADR_MFP_SYNC    16'h0202
`define SCC_ADR_IRQ_MASK    16'h0209
`define SCC_ADR_IRQ_MODE    16'h020a
`define SCC_ADR_WDOG        16'h020b
`define SCC_ADR_OUT_EN      16'h0400
`define SCC_ADR_SYNC_MODE   16'h0401
`define SCC_ADR_PROF_MODE   16'h0500
`define SCC_ADR_CAL_SYNC    16'h0a02
`define SCC_ADR_PROF_SEL    16'h0a0d
`define SCC_ADR_STRAP       16'h0f00
`define SCC_ADR_STATUS      16'h0f01

// field positions
`define SCC_IOUPD_BIT       0
`define SCC_CAL_BIT         0
`define SCC_SYNC_BIT        1
`define SCC_SYNC_PIN_EN_BIT 3

// reset values
`define SCC_SYSCLK_PER_RST  8'h00
`define SCC_MFP_OE_RST      8'h00
`define SCC_MFP_OUT_RST     8'h00
`define SCC_MFP_SYNC_RST    4'h0
`define SCC_IRQ_MASK_RST    8'hff
`define SCC_IRQ_MODE_RST    1'h0
`define SCC_WDOG_RST        1'h0
`define SCC_OUT_EN_RST      2'h0
`define SCC_SYNC_MODE_RST   2'h0
`define SCC_PROF_MODE_RST   1'h0
`define SCC_CAL_SYNC_RST    2'h0
`define SCC_PROF_SEL_RST    8'h00

`endif

// [scc_host_model.sv]
`include "scc_consts.svh"
`default_nettype none
module scc_host_model (
    input  wire logic        clock,
    input  wire logic        regReady,
    input  wire logic [7:0]  regRdata,
    output var  logic        regWrite,
    output var  logic        regRead,
    output var  logic [15:0] regAddr,
    output var  logic [7:0]  regWdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle from time zero
    initial
    begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 16'h0000;
        regWdata = 8'h00;
    end

    // strobe held for the taking edge only; a missing ready reads as ee
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        #2;
        regWrite = w;
        regRead  = !w;
        regAddr  = a;
        regWdata = d;
        @(posedge clock);
        #2;
        regWrite = 1'b0;
        regRead  = 1'b0;
        q = (regReady === 1'b1) ? regRdata : 8'hee;
        @(posedge clock);
        #2;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        xfer(1'b0, a, 8'h00, q);
    endtask

    // staged settings become active only here
    task automatic update();
        wr(`SCC_ADR_IO_UPDATE, 8'h01);
    endtask

    // system clock group goes first, then an update
    task automatic program_sysclk(input logic [7:0] per);
        wr(`SCC_ADR_SYSCLK_PER, per);
        update();
    endtask

    // set, update, clear, update: calibration runs in background
    task automatic calibrate();
        wr(`SCC_ADR_CAL_SYNC, 8'h01);
        update();
        wr(`SCC_ADR_CAL_SYNC, 8'h00);
        update();
    endtask

    // software sync pulse for manual distribution start
    task automatic sync_pulse();
        wr(`SCC_ADR_CAL_SYNC, 8'h02);
        update();
        wr(`SCC_ADR_CAL_SYNC, 8'h00);
        update();
    endtask
endmodule
`default_nettype wire

// [scc_pkg.sv]
`default_nettype none
package scc_pkg;

    // power-up sequencing states, one-hot
    typedef enum logic [2:0] {
        SCC_OFF = 3'h1,
        SCC_POR = 3'h2,
        SCC_RUN = 3'h4
    } scc_power_e;

    // one image of the control registers, used staged and active
    typedef struct packed {
        logic [7:0] sysclkPeriod;
        logic [7:0] mfpOe;
        logic [7:0] mfpOut;
        logic [3:0] mfpSyncSel;
        logic [7:0] irqMask;
        logic       irqMode;
        logic       wdEnable;
        logic [1:0] outEnable;
        logic [1:0] syncMode;
        logic       autoProfile;
        logic [1:0] calSync;
        logic [7:0] profileSel;
    } scc_ctrl_s;

endpackage
`default_nettype wire

// [scc_strap_boot.sv]
`include "scc_consts.svh"
`default_nettype none
module scc_strap_boot (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       supplyValid,
    input  wire logic       resetPinN,
    input  wire logic [7:0] bootPinIn,
    output logic      [7:0] bootPinOut,
    output logic      [7:0] bootPinOe,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [15:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            regReady,
    input  wire logic       phaseLock,
    input  wire logic       freqLock,
    output logic            deviceInReset,
    output logic      [7:0] strapCaptureValue,
    output logic            spiMode,
    output logic      [2:0] i2cAddrLsb,
    output logic            eepromLoadStart,
    output logic      [4:0] eepromCondition,
    output logic      [7:0] sysclkPeriod,
    output logic            sysclkCalStart,
    output logic      [7:0] irqMask,
    output logic            irqMode,
    output logic            watchdogEnable,
    output logic      [1:0] clockOutEnable,
    output logic            acquireStart,
    output logic      [7:0] profileStart
);

    localparam scc_pkg::scc_ctrl_s CTRL_RST = '{
        sysclkPeriod: `SCC_SYSCLK_PER_RST,
        mfpOe:        `SCC_MFP_OE_RST,
        mfpOut:       `SCC_MFP_OUT_RST,
        mfpSyncSel:   `SCC_MFP_SYNC_RST,
        irqMask:      `SCC_IRQ_MASK_RST,
        irqMode:      `SCC_IRQ_MODE_RST,
        wdEnable:     `SCC_WDOG_RST,
        outEnable:    `SCC_OUT_EN_RST,
        syncMode:     `SCC_SYNC_MODE_RST,
        autoProfile:  `SCC_PROF_MODE_RST,
        calSync:      `SCC_CAL_SYNC_RST,
        profileSel:   `SCC_PROF_SEL_RST
    };

    logic [7:0]            pinSync;
    logic [1:0]            ctlSync;
    logic [7:0]            pinSyncPrev;
    scc_pkg::scc_power_e   state;
    scc_pkg::scc_power_e   next_state;
    logic [1:0]            porCount;
    logic                  resetPrev;
    logic                  distRun;
    scc_pkg::scc_ctrl_s    staged;
    scc_pkg::scc_ctrl_s    next_staged;
    scc_pkg::scc_ctrl_s    active;

    // pins and supply detect come from outside the clock domain
    scc_sync2 #(.WIDTH(8)) uPinSync (
        .clock   (clock),     .rst_n   (rst_n),
        .asyncIn (bootPinIn), .syncOut (pinSync));
    scc_sync2 #(.WIDTH(2)) uCtlSync (
        .clock   (clock),     .rst_n   (rst_n),
        .asyncIn ({supplyValid, resetPinN}), .syncOut (ctlSync));

    // reset sources
    wire supplyOk     = ctlSync[1];
    wire extPinReset  = ~ctlSync[0];
    wire porPulse     = (state == scc_pkg::SCC_POR);
    wire deviceReset  = (state != scc_pkg::SCC_RUN) | extPinReset;
    wire releasePulse = resetPrev & ~deviceReset;
    wire porDone      = (porCount == 2'(`SCC_POR_CYC - 1));
    // power-up pulse sequencer
    always_comb
    begin
        next_state = state;
        unique case (state)
            scc_pkg::SCC_OFF: if (supplyOk) next_state = scc_pkg::SCC_POR;
            scc_pkg::SCC_POR: if (porDone) next_state = scc_pkg::SCC_RUN;
            scc_pkg::SCC_RUN: if (!supplyOk) next_state = scc_pkg::SCC_OFF;
            default:          next_state = scc_pkg::SCC_OFF;
        endcase
    end

    // pulse length counted only inside the pulse state
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state    <= scc_pkg::SCC_OFF;
            porCount <= 2'h0;
        end
        else
        begin
            state    <= next_state;
            porCount <= porPulse ? porCount + 2'h1 : 2'h0;
        end
    end

    // strap latch is transparent while reset holds, closes on release
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            strapCaptureValue <= 8'h00;
            resetPrev         <= 1'h1;
            deviceInReset     <= 1'h1;
        end
        else
        begin
            if (deviceReset)
                strapCaptureValue <= pinSync;
            resetPrev     <= deviceReset;
            deviceInReset <= deviceReset;
        end
    end

    // protocol and loader decisions taken once, at reset release
    wire strapSpi  = (strapCaptureValue[2:0] == 3'h0);
    wire strapLoad = (strapCaptureValue[7:3] != 5'h00);
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            spiMode         <= 1'h1;
            i2cAddrLsb      <= 3'h0;
            eepromLoadStart <= 1'h0;
            eepromCondition <= 5'h00;
        end
        else
        begin
            eepromLoadStart <= releasePulse & strapLoad;
            if (releasePulse)
            begin
                spiMode         <= strapSpi;
                i2cAddrLsb      <= strapCaptureValue[2:0];
                eepromCondition <= strapCaptureValue[7:3];
            end
        end
    end

    // register write decode
    wire hitIo       = regWrite & (regAddr == `SCC_ADR_IO_UPDATE);
    wire ioUpdate    = hitIo & regWdata[`SCC_IOUPD_BIT];
    wire wrPeriod    = regWrite & (regAddr == `SCC_ADR_SYSCLK_PER);
    wire wrMfpOe     = regWrite & (regAddr == `SCC_ADR_MFP_OE);
    wire wrMfpOut    = regWrite & (regAddr == `SCC_ADR_MFP_OUT);
    wire wrMfpSync   = regWrite & (regAddr == `SCC_ADR_MFP_SYNC);
    wire wrIrqMask   = regWrite & (regAddr == `SCC_ADR_IRQ_MASK);
    wire wrIrqMode   = regWrite & (regAddr == `SCC_ADR_IRQ_MODE);
    wire wrWdog      = regWrite & (regAddr == `SCC_ADR_WDOG);
    wire wrOutEn     = regWrite & (regAddr == `SCC_ADR_OUT_EN);
    wire wrSyncMode  = regWrite & (regAddr == `SCC_ADR_SYNC_MODE);
    wire wrProfMode  = regWrite & (regAddr == `SCC_ADR_PROF_MODE);
    wire wrCalSync   = regWrite & (regAddr == `SCC_ADR_CAL_SYNC);
    wire wrProfSel   = regWrite & (regAddr == `SCC_ADR_PROF_SEL);
    wire ctrlReset   = ~rst_n | deviceReset;
    // staged image takes host writes; nothing acts on them yet
    always_comb
    begin
        next_staged = staged;
        if (wrPeriod)   next_staged.sysclkPeriod = regWdata;
        if (wrMfpOe)    next_staged.mfpOe        = regWdata;
        if (wrMfpOut)   next_staged.mfpOut       = regWdata;
        if (wrMfpSync)  next_staged.mfpSyncSel   = regWdata[3:0];
        if (wrIrqMask)  next_staged.irqMask      = regWdata;
        if (wrIrqMode)  next_staged.irqMode      = regWdata[0];
        if (wrWdog)     next_staged.wdEnable     = regWdata[0];
        if (wrOutEn)    next_staged.outEnable    = regWdata[1:0];
        if (wrSyncMode) next_staged.syncMode     = regWdata[1:0];
        if (wrProfMode) next_staged.autoProfile  = regWdata[0];
        if (wrCalSync)  next_staged.calSync      = regWdata[1:0];
        if (wrProfSel)  next_staged.profileSel   = regWdata;
    end

    // any reset restores both images, so a skipped load keeps defaults
    always_ff @(posedge clock)
    begin
        if (ctrlReset)
        begin
            staged <= CTRL_RST;
            active <= CTRL_RST;
        end
        else
        begin
            staged <= next_staged;
            if (ioUpdate)
                active <= staged;
        end
    end

    // events caused by an update, judged on the image being copied
    wire calRise  = ioUpdate & staged.calSync[`SCC_CAL_BIT]
                    & ~active.calSync[`SCC_CAL_BIT];
    wire syncRise = ioUpdate & staged.calSync[`SCC_SYNC_BIT]
                    & ~active.calSync[`SCC_SYNC_BIT];
    wire manAcq   = ioUpdate & ~staged.autoProfile;
    wire autoAcq  = ioUpdate & staged.autoProfile;

    // sync from a boot pin only when that pin is an input
    wire [2:0] syncPinIdx = active.mfpSyncSel[2:0];
    wire [7:0] pinRise    = pinSync & ~pinSyncPrev;
    wire pinSyncHit = active.mfpSyncSel[`SCC_SYNC_PIN_EN_BIT]
                      & pinRise[syncPinIdx]
                      & ~active.mfpOe[syncPinIdx];
    wire lockSync   = (active.syncMode[0] & phaseLock)
                      | (active.syncMode[1] & freqLock);
    wire syncEvent  = syncRise | pinSyncHit | lockSync;

    // one-shot outputs of the update path
    always_ff @(posedge clock)
    begin
        if (ctrlReset)
        begin
            sysclkCalStart <= 1'h0;
            acquireStart   <= 1'h0;
            profileStart   <= 8'h00;
        end
        else
        begin
            sysclkCalStart <= calRise;
            acquireStart   <= manAcq;
            profileStart   <= autoAcq ? staged.profileSel : 8'h00;
        end
    end

    // distribution stays quiet until a sync event arms it
    always_ff @(posedge clock)
    begin
        if (ctrlReset)
        begin
            distRun        <= 1'h0;
            clockOutEnable <= 2'h0;
        end
        else
        begin
            if (syncEvent)
                distRun <= 1'h1;
            clockOutEnable <= distRun ? active.outEnable : 2'h0;
        end
    end

    // pin drive: a reset drops every enable on the next edge
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            bootPinOe   <= 8'h00;
            bootPinOut  <= 8'h00;
            pinSyncPrev <= 8'h00;
        end
        else
        begin
            bootPinOe   <= deviceReset ? 8'h00 : active.mfpOe;
            bootPinOut  <= active.mfpOut;
            pinSyncPrev <= pinSync;
        end
    end

    // active image fields drive the device directly
    assign sysclkPeriod   = active.sysclkPeriod;
    assign irqMask        = active.irqMask;
    assign irqMode        = active.irqMode;
    assign watchdogEnable = active.wdEnable;

    // read mux shows the staged image; update bit always reads zero
    wire [7:0] statusWord = {5'h00, distRun, deviceReset, spiMode};
    wire [7:0] rdMux =
        (regAddr == `SCC_ADR_SYSCLK_PER) ? staged.sysclkPeriod :
        (regAddr == `SCC_ADR_MFP_OE)     ? staged.mfpOe :
        (regAddr == `SCC_ADR_MFP_OUT)    ? staged.mfpOut :
        (regAddr == `SCC_ADR_MFP_SYNC)   ? {4'h0, staged.mfpSyncSel} :
        (regAddr == `SCC_ADR_IRQ_MASK)   ? staged.irqMask :
        (regAddr == `SCC_ADR_IRQ_MODE)   ? {7'h00, staged.irqMode} :
        (regAddr == `SCC_ADR_WDOG)       ? {7'h00, staged.wdEnable} :
        (regAddr == `SCC_ADR_OUT_EN)     ? {6'h00, staged.outEnable} :
        (regAddr == `SCC_ADR_SYNC_MODE)  ? {6'h00, staged.syncMode} :
        (regAddr == `SCC_ADR_PROF_MODE)  ? {7'h00, staged.autoProfile} :
        (regAddr == `SCC_ADR_CAL_SYNC)   ? {6'h00, staged.calSync} :
        (regAddr == `SCC_ADR_PROF_SEL)   ? staged.profileSel :
        (regAddr == `SCC_ADR_STRAP)      ? strapCaptureValue :
        (regAddr == `SCC_ADR_STATUS)     ? statusWord : 8'h00;
    // every access answers one cycle later
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            regRdata <= 8'h00;
            regReady <= 1'h0;
        end
        else
        begin
            regRdata <= regRead ? rdMux : 8'h00;
            regReady <= regRead | regWrite;
        end
    end

    localparam int PIN_HIZ_CYC = `SCC_PIN_HIZ_CYC;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_POR_WIDTH: assert property (
        $rose(porPulse) |-> porPulse [*3] ##1 !porPulse)
        else $error("power-up pulse is not three cycles long");
    AST_PIN_HIZ: assert property (
        $rose(porPulse) |-> ##[1:PIN_HIZ_CYC] (bootPinOe == 8'h00))
        else $error("boot pins still driven after power-up pulse");
    AST_OE_IN_RESET: assert property (
        deviceReset |=> (bootPinOe == 8'h00))
        else $error("boot pin driven during reset");
    AST_STRAP_MAP: assert property (
        deviceReset |=> (strapCaptureValue == $past(pinSync)))
        else $error("strap bits do not follow pins");
    AST_STRAP_HOLD: assert property (
        !deviceReset && !$past(deviceReset) |-> $stable(strapCaptureValue))
        else $error("strap changed outside reset");
    AST_SPI_SEL: assert property (
        releasePulse && strapSpi |=> spiMode)
        else $error("spi not selected for zero strap");
    AST_I2C_SEL: assert property (
        releasePulse && !strapSpi |=> !spiMode
        && (i2cAddrLsb == $past(strapCaptureValue[2:0])))
        else $error("i2c selection or address wrong");
    AST_EE_SKIP: assert property (
        releasePulse && !strapLoad |=> !eepromLoadStart)
        else $error("eeprom load started for zero condition");
    AST_EE_LOAD: assert property (
        releasePulse && strapLoad |=> eepromLoadStart
        && (eepromCondition == $past(strapCaptureValue[7:3])))
        else $error("eeprom load missing or wrong condition");
    AST_NO_UPDATE_HOLD: assert property (
        !ioUpdate && !deviceReset |=> $stable(active))
        else $error("active settings changed without update");
    AST_UPDATE_COPY: assert property (
        ioUpdate && !deviceReset |=> (active == $past(staged)))
        else $error("update did not copy staged image");
    AST_CAL_START: assert property (
        calRise && !deviceReset |=> sysclkCalStart ##1 !sysclkCalStart)
        else $error("calibration start not a single pulse");
    AST_DEFAULTS: assert property (
        deviceReset |=> (irqMask == `SCC_IRQ_MASK_RST) && !irqMode
        && !watchdogEnable && (clockOutEnable == 2'h0))
        else $error("defaults wrong after reset");
    AST_ACQ_MANUAL: assert property (
        manAcq && !deviceReset |=> acquireStart && (profileStart == 8'h00))
        else $error("manual acquisition not started");
    AST_ACQ_AUTO: assert property (
        autoAcq && !deviceReset |=> !acquireStart
        && (profileStart == $past(staged.profileSel)))
        else $error("profile state machines not started");
    AST_LOCK_OUT: assert property (
        lockSync && !deviceReset ##1 !deviceReset
        |=> (clockOutEnable == $past(active.outEnable)))
        else $error("outputs not started on lock");

    COV_EE_LOAD: cover property (releasePulse && strapLoad);
    COV_I2C: cover property (releasePulse && !strapSpi);
    COV_UPDATE: cover property (ioUpdate ##[1:20] calRise);
    COV_DIST_RUN: cover property ($rose(distRun));

endmodule
`default_nettype wire

// [scc_sync2.sv]
`default_nettype none
module scc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stage1  <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1  <= asyncIn;
            syncOut <= stage1;
        end
    end

endmodule
`default_nettype wire

// [testbench.sv]
`include "scc_consts.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clock, rst_n, supplyValid, resetPinN, phaseLock, freqLock;
    logic      [7:0] pins;
    wire logic [7:0] bootPinIn, bootPinOut, bootPinOe, regRdata, irqMask;
    wire logic [7:0] strapCaptureValue, sysclkPeriod, profileStart, regWdata;
    wire logic       regWrite, regRead, regReady, deviceInReset, spiMode;
    wire logic       eepromLoadStart, sysclkCalStart, irqMode, acquireStart;
    wire logic       watchdogEnable;
    wire logic [15:0] regAddr;
    wire logic [2:0] i2cAddrLsb;
    wire logic [4:0] eepromCondition;
    wire logic [1:0] clockOutEnable;
    int              failures = 0;
    int              cmp_count = 0;
    int              calCnt = 0;
    int              acqCnt = 0;
    int              eeCnt = 0;
    logic      [7:0] profSeen = 8'h00;
    logic      [7:0] q;

    // pull resistors win wherever the device does not drive the pin
    assign bootPinIn = (bootPinOe & bootPinOut) | (~bootPinOe & pins);

    scc_strap_boot scc_strap_boot_i (
        .clock(clock), .rst_n(rst_n), .supplyValid(supplyValid),
        .resetPinN(resetPinN), .bootPinIn(bootPinIn),
        .bootPinOut(bootPinOut), .bootPinOe(bootPinOe),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .regReady(regReady),
        .phaseLock(phaseLock), .freqLock(freqLock),
        .deviceInReset(deviceInReset),
        .strapCaptureValue(strapCaptureValue), .spiMode(spiMode),
        .i2cAddrLsb(i2cAddrLsb), .eepromLoadStart(eepromLoadStart),
        .eepromCondition(eepromCondition), .sysclkPeriod(sysclkPeriod),
        .sysclkCalStart(sysclkCalStart), .irqMask(irqMask),
        .irqMode(irqMode), .watchdogEnable(watchdogEnable),
        .clockOutEnable(clockOutEnable), .acquireStart(acquireStart),
        .profileStart(profileStart)
    );

    scc_host_model host_i (
        .clock(clock), .regReady(regReady), .regRdata(regRdata),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata)
    );

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // pulse counters, so a pulse one cycle long cannot slip between checks
    always @(posedge clock)
    begin
        if (sysclkCalStart === 1'b1) calCnt++;
        if (acquireStart === 1'b1) acqCnt++;
        if (eepromLoadStart === 1'b1) eeCnt++;
        if (profileStart !== 8'h00) profSeen = profileStart;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string m);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask

    // reset through the pin with a strap pattern, wait for release
    task automatic pin_reset(input logic [7:0] p);
        int n;
        pins = p;
        resetPinN = 1'b0;
        cyc(5);
        chk(bootPinOe, 8'h00, "pins driven in reset");
        resetPinN = 1'b1;
        n = 0;
        while (deviceInReset !== 1'b0 && n < 20)
        begin
            cyc(1);
            n++;
        end
        chk({7'h0, deviceInReset}, 8'h00, "reset not released");
        cyc(2);
    endtask

    task automatic t_power();
        int n;
        cyc(2);
        chk({7'h0, deviceInReset}, 8'h01, "out of reset early");
        supplyValid = 1'b1;
        n = 0;
        while (deviceInReset !== 1'b0 && n < 20)
        begin
            chk(bootPinOe, 8'h00, "pins driven at power-up");
            cyc(1);
            n++;
        end
        chk(8'(n), 8'h07, "reset pulse length");
        chk(irqMask, 8'hff, "mask default");
        chk({7'h0, irqMode}, 8'h00, "pin mode default");
        chk({7'h0, watchdogEnable}, 8'h00, "watchdog default");
        chk({6'h0, clockOutEnable}, 8'h00, "out enable default");
        $display("test power done");
    endtask

    task automatic t_straps();
        logic [7:0] pat [5] = '{8'h00, 8'h0b, 8'h07, 8'hf8, 8'h85};
        int e0;
        foreach (pat[i])
        begin
            e0 = eeCnt;
            pin_reset(pat[i]);
            pins = ~pat[i]; // changes after release are ignored
            cyc(4);
            chk(strapCaptureValue, pat[i], "strap");
            chk({7'h0, spiMode}, 8'(pat[i][2:0] == 3'h0), "spi");
            chk({5'h0, i2cAddrLsb}, {5'h0, pat[i][2:0]}, "addr");
            chk({3'h0, eepromCondition}, {3'h0, pat[i][7:3]}, "cond");
            chk(8'(eeCnt - e0), 8'(pat[i][7:3] != 5'h0), "load");
            chk(irqMask, 8'hff, "defaults kept");
            host_i.rd(`SCC_ADR_STRAP, q);
            chk(q, pat[i], "strap read");
        end
        $display("test straps done");
    endtask

    task automatic t_update();
        host_i.wr(`SCC_ADR_IRQ_MASK, 8'h00);
        host_i.wr(`SCC_ADR_WDOG, 8'h01);
        host_i.wr(`SCC_ADR_MFP_OE, 8'h10);
        host_i.wr(`SCC_ADR_MFP_OUT, 8'h10);
        host_i.wr(`SCC_ADR_IRQ_MODE, 8'h01);
        chk(irqMask, 8'hff, "staged mask active");
        chk({7'h0, irqMode}, 8'h00, "staged mode active");
        chk({7'h0, watchdogEnable}, 8'h00, "watchdog early");
        chk(bootPinOe, 8'h00, "pin driven early");
        host_i.program_sysclk(8'h42);
        chk(sysclkPeriod, 8'h42, "period");
        chk(irqMask, 8'h00, "mask");
        chk({7'h0, watchdogEnable}, 8'h01, "watchdog");
        chk(bootPinOe, 8'h10, "pin oe");
        chk(bootPinOut, 8'h10, "pin out");
        chk({7'h0, irqMode}, 8'h01, "pin mode");
        host_i.rd(`SCC_ADR_SYSCLK_PER, q);
        chk(q, 8'h42, "period read");
        host_i.rd(`SCC_ADR_IO_UPDATE, q);
        chk(q, 8'h00, "update bit");
        host_i.wr(`SCC_ADR_STRAP, 8'h55);
        host_i.rd(`SCC_ADR_STRAP, q);
        chk(q, 8'h85, "read-only strap");
        host_i.rd(16'h0fff, q);
        chk(q, 8'h00, "unmapped");
        $display("test update done");
    endtask

    task automatic t_acquire();
        int c0;
        c0 = calCnt;
        host_i.calibrate();
        chk(8'(calCnt - c0), 8'h01, "calibration starts");
        c0 = acqCnt;
        host_i.update();
        chk(8'(acqCnt - c0), 8'h01, "manual acquire");
        host_i.wr(`SCC_ADR_PROF_MODE, 8'h01);
        host_i.wr(`SCC_ADR_PROF_SEL, 8'h5a);
        host_i.update();
        chk(profSeen, 8'h5a, "profile start");
        $display("test acquire done");
    endtask

    task automatic t_sync();
        pin_reset(8'h00);
        host_i.wr(`SCC_ADR_OUT_EN, 8'h03);
        host_i.update();
        cyc(3);
        chk({6'h0, clockOutEnable}, 8'h00, "no sync yet");
        host_i.sync_pulse();
        cyc(3);
        chk({6'h0, clockOutEnable}, 8'h03, "soft sync");
        host_i.rd(`SCC_ADR_STATUS, q);
        chk(q, 8'h05, "status word");
        pin_reset(8'h00);
        chk({6'h0, clockOutEnable}, 8'h00, "cleared by reset");
        host_i.wr(`SCC_ADR_OUT_EN, 8'h03);
        host_i.wr(`SCC_ADR_SYNC_MODE, 8'h01);
        host_i.update();
        cyc(3);
        chk({6'h0, clockOutEnable}, 8'h00, "before lock");
        phaseLock = 1'b1;
        cyc(4);
        chk({6'h0, clockOutEnable}, 8'h03, "phase lock");
        phaseLock = 1'b0;
        pin_reset(8'h00);
        host_i.wr(`SCC_ADR_OUT_EN, 8'h01);
        host_i.wr(`SCC_ADR_SYNC_MODE, 8'h02);
        host_i.update();
        freqLock = 1'b1;
        cyc(4);
        chk({6'h0, clockOutEnable}, 8'h01, "freq lock");
        freqLock = 1'b0;
        pin_reset(8'h00);
        host_i.wr(`SCC_ADR_MFP_SYNC, 8'h0a);
        host_i.wr(`SCC_ADR_OUT_EN, 8'h02);
        host_i.update();
        cyc(3);
        chk({6'h0, clockOutEnable}, 8'h00, "pin idle");
        pins = 8'h04;
        cyc(6);
        chk({6'h0, clockOutEnable}, 8'h02, "pin sync");
        pins = 8'h00;
        $display("test sync done");
    endtask

    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // the whole run needs a few hundred cycles; this is ample
    initial
    begin
        #400000;
        failures++;
        final_report();
    end

    initial
    begin
        rst_n = 1'b0;
        supplyValid = 1'b0;
        resetPinN = 1'b1;
        phaseLock = 1'b0;
        freqLock = 1'b0;
        pins = 8'h00;
        repeat (4) @(posedge clock);
        #2;
        rst_n = 1'b1;
        t_power();
        t_straps();
        t_update();
        t_acquire();
        t_sync();
        final_report();
    end
endmodule
`default_nettype wire
